// >>> design/synth_post_div_pkg.sv
// Constants shared by the post-divider frame and clock generator
`default_nettype none
package synth_post_div_pkg;
  // ==========================================================
  // Register map (byte registers, three bytes per divider)
  localparam logic [7:0]  DIV_C_ADDR   = 8'h92;
  localparam logic [7:0]  DIV_D_ADDR   = 8'h95;
  localparam logic [1:0]  CFG_BYTES    = 2'h3;
  localparam logic [1:0]  COMMIT_BYTE  = 2'h2;
  localparam logic [23:0] DIV_C_RESET  = 24'h000032;
  localparam logic [23:0] DIV_D_RESET  = 24'h000032;
  // ==========================================================
  // Field layout
  localparam int          MODE_LSB     = 20;
  localparam int          TYPE_BIT     = 19;
  localparam int          POL_BIT      = 18;
  localparam int          SRC_LSB      = 16;
  localparam int          RATE_W       = 16;
  localparam logic [3:0]  MODE_SPECIAL = 4'hf;
  // ==========================================================
  // Source select codes
  localparam logic [1:0]  SRC_A        = 2'h0;
  localparam logic [1:0]  SRC_B        = 2'h1;
  localparam logic [1:0]  C_SRC_LF     = 2'h2;
  localparam logic [1:0]  C_SRC_D      = 2'h3;
  localparam logic [1:0]  D_SRC_C      = 2'h2;
  localparam logic [1:0]  D_SRC_LF     = 2'h3;
  // ==========================================================
  // Clock cycles per tick at twice the base frequency
  localparam int          BASE_TICK_CYCLES = 100;
endpackage
`default_nettype wire

// >>> design/post_divider_cfg_reg.sv
// One 24-bit post-divider configuration register with coherent apply
`default_nettype none
module post_divider_cfg_reg
  import synth_post_div_pkg::*;
#(
  parameter logic [7:0]  BASE  = DIV_C_ADDR,
  parameter logic [23:0] RESET = DIV_C_RESET
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  output logic      [23:0] cfg,
  output logic      [23:0] shadow,
  output logic             load,
  output logic             hit,
  output logic      [7:0]  rbyte
);
  // ==========================================================
  // Decode
  wire logic [7:0] offset  = reg_addr - BASE;
  wire logic       in_map  = (reg_addr >= BASE) && (offset < {6'h0, CFG_BYTES});
  wire logic [1:0] idx     = offset[1:0];
  wire logic       wr      = reg_we && in_map;
  wire logic       commit  = wr && (idx == COMMIT_BYTE);
  logic      [23:0] next_shadow;

  always_comb
  begin
    next_shadow = shadow;
    if (wr)
    begin
      next_shadow[idx * 8 +: 8] = reg_wdata;
    end
  end

  assign hit   = in_map;
  assign rbyte = shadow[idx * 8 +: 8];

  // ==========================================================
  // Storage; bytes collect in the shadow, generator sees only commits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shadow <= RESET;
      cfg    <= RESET;
      load   <= 1'b0;
    end
    else
    begin
      shadow <= next_shadow;
      load   <= commit;                   // R15
      if (commit)
      begin
        cfg <= next_shadow;               // R15
      end
    end
  end
endmodule // post_divider_cfg_reg
`default_nettype wire

// >>> design/synth_post_divider_frame_gen.sv
// Post-dividers C and D: divided clock, low-frequency clock or frame pulse
`default_nettype none
// Contract
// (R1) C mode not all ones: 50% clock, synth clock divided by full 24 bits.
// (R2) C mode all ones, source 10: low-frequency clock, 2x base over bits 15:0.
// (R3) C mode all ones, other source: frame pulse one selected-clock period wide.
// (R4) Frame mode bit 18 picks polarity, 0 positive; else divider bit.
// (R5) Frame mode bit 19: 0 boundary mid-pulse, 1 at first edge.
// (R6) Mode field separates frame pulse, low-frequency clock and regular clock.
// (R7) D frame mode: bits 15:0 count selected-clock periods between pulses.
// (R8) D mode all ones, source 11: low-frequency clock, 2x base over bits 15:0.
// (R9) D outside all-ones mode: full 24 bits divide the synth clock.
// (R10) D source: 00 A, 01 B, 10 C, 11 low-frequency clock.
// (R11) Duty within 45-55% for even divisors and odd divisors from 41.
// (R12) Software avoids small odd divisors by raising synth rate, using eight.
// (R13) C source: 00 A, 01 B, 10 low-frequency clock, 11 D.
// (R14) C frame mode: bits 15:0 count selected-clock periods between pulses.
// (R15) Configuration reaches the generator only as one complete 24-bit value.
module synth_post_divider_frame_gen
  import synth_post_div_pkg::*;
#(
  parameter int BASE_TICKS = BASE_TICK_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       sibling_a_clk,
  input  wire logic       sibling_b_clk,
  output logic      [7:0] reg_rdata,
  output logic            divider_c_out,
  output logic            divider_d_out
);
  // ==========================================================
  // Configuration registers
  logic [23:0] cfg    [2];
  logic [23:0] shadow [2];
  logic [1:0]  load;
  logic [1:0]  hit;
  logic [7:0]  rbyte  [2];
  logic [1:0]  out;

  post_divider_cfg_reg #(
    .BASE  (DIV_C_ADDR),
    .RESET (DIV_C_RESET)
  ) u_divider_c_value (
    .clk       (clk),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .cfg       (cfg[0]),
    .shadow    (shadow[0]),
    .load      (load[0]),
    .hit       (hit[0]),
    .rbyte     (rbyte[0])
  );

  post_divider_cfg_reg #(
    .BASE  (DIV_D_ADDR),
    .RESET (DIV_D_RESET)
  ) u_divider_d_value (
    .clk       (clk),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_we    (reg_we),
    .cfg       (cfg[1]),
    .shadow    (shadow[1]),
    .load      (load[1]),
    .hit       (hit[1]),
    .rbyte     (rbyte[1])
  );

  // ==========================================================
  // Register read; unmapped addresses read zero
  // Reads return the shadow, so software sees its own partial writes
  wire logic [7:0] next_rdata = hit[0] ? rbyte[0] : (hit[1] ? rbyte[1] : 8'h00);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Base tick at twice the base frequency, shared by both dividers
  // Free running, so both low-frequency outputs keep one phase reference
  logic [31:0] tick_cnt;
  logic        lf_tick;
  wire logic   tick_wrap = (tick_cnt >= 32'(BASE_TICKS - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt <= 32'h0;
      lf_tick  <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick_wrap ? 32'h0 : tick_cnt + 32'h1;
      lf_tick  <= tick_wrap;
    end
  end

  // ==========================================================
  // Source vectors indexed by the select code
  // C and D may count each other; both outputs are registers, so no loop
  wire logic [3:0] src_vec [2];
  wire logic [1:0] lf_code [2];

  assign src_vec[0] = {out[1], 1'b0, sibling_b_clk, sibling_a_clk}; // R13
  assign src_vec[1] = {1'b0, out[0], sibling_b_clk, sibling_a_clk}; // R10
  assign lf_code[0] = C_SRC_LF;                                     // R13
  assign lf_code[1] = D_SRC_LF;                                     // R10

  // ==========================================================
  // One generator per divider
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_div
      wire logic [23:0] c        = cfg[ch];
      wire logic [1:0]  sel      = c[SRC_LSB +: 2];
      wire logic        special  = (c[MODE_LSB +: 4] == MODE_SPECIAL);       // R6
      wire logic        lf_mode  = special && (sel == lf_code[ch]);          // R2 R8
      wire logic        frm_mode = special && !lf_mode;                      // R3
      wire logic [23:0] rate     = {8'h00, c[RATE_W - 1:0]};
      wire logic [23:0] limit    = special ? rate : c;                       // R1 R9
      wire logic        src_clk  = src_vec[ch][sel];                         // R10 R13
      wire logic        neg      = c[POL_BIT];                               // R4
      wire logic        first_ed = c[TYPE_BIT];                              // R5

      logic [23:0] cnt;
      logic        src_prev;
      logic        pulse;
      logic        level;

      wire logic src_rise = src_clk && !src_prev;
      wire logic src_fall = !src_clk && src_prev;
      wire logic step     = lf_mode ? lf_tick : (frm_mode ? src_rise : 1'b1);
      wire logic last     = (limit != 24'h0) && (cnt >= limit - 24'h1);
      // Low phase takes the odd cycle, so duty is (n-1)/2n for odd n
      wire logic next_lvl = (cnt < (limit >> 1));                            // R11
      wire logic edge_hit = first_ed ? src_rise : src_fall;                  // R5
      logic [23:0] next_cnt;
      logic        next_pulse;
      logic        next_out;

      // ==========================================================
      // Counter
      // Load restarts the count so a new divisor never sees a stale value
      always_comb
      begin
        next_cnt = cnt;
        if (load[ch] || limit == 24'h0)
        begin
          next_cnt = 24'h0;
        end
        else if (step)
        begin
          next_cnt = last ? 24'h0 : cnt + 24'h1;                             // R1 R7 R14
        end
      end

      // ==========================================================
      // Frame pulse
      // Zero rate parks the line at its idle level
      always_comb
      begin
        next_pulse = pulse;
        if (!frm_mode || rate == 24'h0 || load[ch])
        begin
          next_pulse = 1'b0;
        end
        else if (edge_hit)
        begin
          // Rises on edge_hit while cnt is at its last value: the fall before the boundary rise, or the boundary rise itself
          next_pulse = last;                                                 // R3 R7 R14
        end
      end

      // ==========================================================
      // Output register
      assign next_out = frm_mode ? (pulse ^ neg) : level;                    // R4

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          cnt      <= 24'h0;
          src_prev <= 1'b0;
          pulse    <= 1'b0;
          level    <= 1'b0;
          out[ch]  <= 1'b0;
        end
        else
        begin
          cnt      <= next_cnt;
          src_prev <= src_clk;
          pulse    <= next_pulse;
          level    <= next_lvl && !load[ch];
          out[ch]  <= next_out;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign divider_c_out = out[0];
  assign divider_d_out = out[1];
endmodule // synth_post_divider_frame_gen
`default_nettype wire

// >>> sim/synth_post_divider_frame_gen_chk.sv
// Port assertions for the post-divider generator
`default_nettype none
module synth_post_divider_frame_gen_chk
  import synth_post_div_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_we,
  input wire logic [7:0] reg_rdata,
  input wire logic       divider_c_out,
  input wire logic       divider_d_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Applied config mirror, updated only on top byte
  logic [15:0] c_sh;
  logic [15:0] d_sh;
  logic [23:0] c_cfg;
  logic [23:0] d_cfg;
  logic        c_idle;
  logic        d_idle;
  logic        mapped;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      c_sh  <= 16'h0032;
      d_sh  <= 16'h0032;
      c_cfg <= 24'h000032;
      d_cfg <= 24'h000032;
    end
    else if (reg_we)
      case (reg_addr)
        8'h92:   c_sh[7:0]  <= reg_wdata;
        8'h93:   c_sh[15:8] <= reg_wdata;
        8'h94:   c_cfg      <= {reg_wdata, c_sh};
        8'h95:   d_sh[7:0]  <= reg_wdata;
        8'h96:   d_sh[15:8] <= reg_wdata;
        8'h97:   d_cfg      <= {reg_wdata, d_sh};
        default: ;
      endcase
  // Rate zero in frame mode parks the line at its idle level
  assign c_idle = c_cfg[23:20] == MODE_SPECIAL && c_cfg[17:16] != C_SRC_LF && c_cfg[15:0] == 0;
  assign d_idle = d_cfg[23:20] == MODE_SPECIAL && d_cfg[17:16] != D_SRC_LF && d_cfg[15:0] == 0;
  assign mapped = reg_addr inside {[8'h92:8'h97]};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !reg_we ##1 !reg_we && $stable(reg_addr);
  endsequence
  sequence s_wr_hold;
    reg_we && mapped ##1 !reg_we && $stable(reg_addr);
  endsequence
  property p_unmapped;
    !mapped |=> reg_rdata == 8'h00;
  endproperty
  property p_readback;
    s_wr_hold |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_quiet;
    s_quiet |=> $stable(reg_rdata);
  endproperty
  property p_release;
    $fell(rst) |-> reg_rdata == 8'h00 && !divider_c_out && !divider_d_out;
  endproperty
  property p_c_restart;
    reg_we && reg_addr == 8'h94 && reg_wdata[7:4] != MODE_SPECIAL |-> ##3 !divider_c_out;
  endproperty
  property p_d_restart;
    reg_we && reg_addr == 8'h97 && reg_wdata[7:4] != MODE_SPECIAL |-> ##3 !divider_d_out;
  endproperty
  property p_c_idle;
    c_idle [*4] |-> divider_c_out == c_cfg[POL_BIT];
  endproperty
  property p_d_idle;
    d_idle [*4] |-> divider_d_out == d_cfg[POL_BIT];
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_readback: assert property (p_readback) else $error("read back differs");
  a_quiet: assert property (p_quiet) else $error("read data moved");
  a_release: assert property (p_release) else $error("reset state wrong");
  a_c_restart: assert property (p_c_restart) else $error("c not restarted");
  a_d_restart: assert property (p_d_restart) else $error("d not restarted");
  a_c_idle: assert property (p_c_idle) else $error("c idle level");
  a_d_idle: assert property (p_d_idle) else $error("d idle level");
endmodule // synth_post_divider_frame_gen_chk
bind synth_post_divider_frame_gen synth_post_divider_frame_gen_chk i_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
  .divider_c_out(divider_c_out), .divider_d_out(divider_d_out));
`default_nettype wire

// >>> sim/sibling_clk_model.sv
// Sibling post-divider clocks A and B
`default_nettype none
module sibling_clk_model #(
  parameter int A_HALF = 5,
  parameter int B_HALF = 3
)(
  input  wire logic clk,
  input  wire logic rst,
  output var logic  a_clk,
  output var logic  b_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Free running, as real sibling dividers never stop
  int a_cnt;
  int b_cnt;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      a_cnt <= 0;
      b_cnt <= 0;
      a_clk <= 1'b0;
      b_clk <= 1'b0;
    end
    else
    begin
      a_cnt <= (a_cnt == A_HALF - 1) ? 0 : a_cnt + 1;
      b_cnt <= (b_cnt == B_HALF - 1) ? 0 : b_cnt + 1;
      a_clk <= (a_cnt == A_HALF - 1) ? ~a_clk : a_clk;
      b_clk <= (b_cnt == B_HALF - 1) ? ~b_clk : b_clk;
    end
endmodule // sibling_clk_model
`default_nettype wire

// >>> sim/synth_post_divider_frame_gen_test.sv
// Self-checking bench for the post-divider generator
`default_nettype none
module synth_post_divider_frame_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Bit 24 picks D; steady high and low cycles (A period 10, B period 6)
  localparam logic [24:0] CFG [13] = '{25'h0000032, 25'h0000008, 25'h1000029,
    25'h0f20004, 25'h1f30006, 25'h0f80003, 25'h0f40003, 25'h1f90002, 25'h1f00003,
    25'h1fa0002, 25'h1000008, 25'h0fb0002, 25'h0f10002};
  localparam int HI [13] = '{25, 4, 20, 8, 12, 10, 20, 6, 10, 30, 4, 8, 6};
  localparam int LO [13] = '{25, 4, 21, 8, 12, 20, 10, 6, 20, 30, 4, 8, 6};
  logic       clk;
  logic       rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_we;
  logic       a_clk;
  logic       b_clk;
  logic [7:0] reg_rdata;
  logic       c_out;
  logic       d_out;
  logic       sel_d;
  logic       mon;
  int         error_cnt;
  int         num_checks;
  assign mon = sel_d ? d_out : c_out;
  sibling_clk_model i_sib (.clk(clk), .rst(rst), .a_clk(a_clk), .b_clk(b_clk));
  synth_post_divider_frame_gen #(.BASE_TICKS(4)) i_dut (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .sibling_a_clk(a_clk),
    .sibling_b_clk(b_clk), .reg_rdata(reg_rdata), .divider_c_out(c_out), .divider_d_out(d_out));
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask
  task automatic wr24(input logic [7:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++)
      wr(a + 8'(i), v[8*i +: 8]);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("read byte", 24'(exp), 24'(reg_rdata));
  endtask
  task automatic step(inout int t);
    @(negedge clk);
    t++;
  endtask
  // First period after a change is discarded, it may be partial
  task automatic measure(input int hi, input int lo);
    int t;
    int h;
    int l;
    t = 0;
    repeat (2)
    begin
      while (mon !== 1'b0 && t < 3000) step(t);
      while (mon !== 1'b1 && t < 3000) step(t);
      h = t;
      while (mon === 1'b1 && t < 3000) step(t);
      l = t;
      while (mon === 1'b0 && t < 3000) step(t);
    end
    chk("high cycles", 24'(hi), 24'(l - h));
    chk("low cycles", 24'(lo), 24'(t - l));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #300000;
    error_cnt++;
    test_done;
  end
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    sel_d = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(8'h91 + 8'(i), (i == 1 || i == 4) ? 8'h32 : 8'h00);
    for (int i = 0; i < 13; i++)
    begin
      sel_d = CFG[i][24];
      wr24(CFG[i][24] ? 8'h95 : 8'h92, CFG[i][23:0]);
      measure(HI[i], LO[i]);
    end
    wr(8'h92, 8'h04);
    measure(6, 6);
    rd(8'h92, 8'h04);
    wr24(8'h92, 24'hf40000);
    wr24(8'h95, 24'hf40000);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("idle levels", 24'h3, {22'h0, c_out, d_out});
    test_done;
  end
endmodule // synth_post_divider_frame_gen_test
`default_nettype wire
